// ===== include/sdsc_pkg.sv
// Package with offsets, field layouts, reset values and codes of the strap/driver bank
package sdsc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_LINE_DRIVER_SELECT = 8'hB4;
    localparam logic [7:0] OFF_POWER_MANAGE_PARAMETER = 8'hB8;
    localparam logic [7:0] OFF_TEST_WORD_ONE = 8'hBC;
    localparam logic [7:0] OFF_TEST_WORD_TWO = 8'hC0;
    localparam logic [7:0] OFF_TEST_WORD_THREE = 8'hC4;
    localparam logic [7:0] OFF_STRAP_PIN_STATUS = 8'hC8;
    localparam int NUM_PORTS = 8;
    localparam int MODE_W = 4;
    localparam logic [31:0] LINE_DRIVER_RESET = 32'h0000_0000;
    localparam int PM_W = 6;
    localparam logic [5:0] PM_RESET_DEFAULT = 6'h00;
    localparam logic [31:0] TEST_WORD_RESET = 32'h0000_0000;
    localparam int STRAP_W = 14;
    localparam int STRAP_LO_BIT = 0;
    localparam int STRAP_HI_BIT = 1;
    localparam int STRAP_DTX_LSB = 2;
    localparam int STRAP_DEQ_LSB = 6;
    localparam int STRAP_RXT_LSB = 10;
    localparam int STRAP_TXT_LSB = 12;
    localparam logic [3:0] MODE_RS232 = 4'h0;
    localparam logic [3:0] MODE_RS422 = 4'h1;
    localparam logic [3:0] MODE_RS485_4W = 4'hB;
    localparam logic [3:0] MODE_RS485_2W = 4'hF;
    // Strap capture runs once after reset release
    typedef enum logic [1:0] {
        CAP_WAIT = 2'b01,
        CAP_DONE = 2'b10
    } sdsc_cap_t;
endpackage

// ===== verification/tb_top.sv
// Self-checking bench for the driver select, power word, test words and strap mirror
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] d;} sdsc_rexp_t;
    logic CLK_SYS = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic [13:0] straps;
    logic av = 1'b0;
    logic [7:0] aa = 8'h00;
    logic [31:0] ad = 32'h0000_0000;
    logic [7:0] p422, p485, phalf;
    logic [5:0] pwr;
    logic [13:0] sv;
    logic [31:0] seed = 32'hFC78B3C0;
    logic [31:0] w;
    logic rd_pend = 1'b0;
    logic [3:0] codes [4] = '{sdsc_pkg::MODE_RS232, sdsc_pkg::MODE_RS422,
        sdsc_pkg::MODE_RS485_4W, sdsc_pkg::MODE_RS485_2W};
    logic [7:0] ro_off [4] = '{8'hBC, 8'hC0, 8'hC4, 8'hC8};
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    sdsc_rexp_t exp_q[$];
    sdsc_rexp_t r;

    sdsc_regs dut_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .LOW_DRIVE_CURRENT_STRAP(straps[0]),
        .HIGH_DRIVE_CURRENT_STRAP(straps[1]), .TRANSMIT_CURRENT_STRAPS(straps[5:2]),
        .DEEMPHASIS_EQ_STRAPS(straps[9:6]), .RX_TERMINATION_STRAPS(straps[11:10]),
        .TX_TERMINATION_STRAPS(straps[13:12]), .AUTOLOAD_VALID(av), .AUTOLOAD_ADDR(aa),
        .AUTOLOAD_DATA(ad), .PORT_RS422(p422), .PORT_RS485(p485), .PORT_RS485_HALF(phalf),
        .POWER_PARAM(pwr), .STRAP_VALUE(sv));

    // Free-running 100 MHz clock
    initial
    begin
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // Galois-free shift feedback keeps the stimulus reproducible
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bus cycles: strobe high for one edge, then a gap edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back({a, e});
        @(posedge CLK_SYS);
        RD <= 1'b0;
    endtask

    task automatic al(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        aa <= a;
        ad <= d;
        av <= 1'b1;
        @(posedge CLK_SYS);
        av <= 1'b0;
    endtask

    // Callers return on the storing edge; the registered mode outputs follow one edge later
    task automatic chk_ports(input logic [31:0] v);
        logic [7:0] e422, e485, ehalf;
        for (int n = 0; n < 8; n++)
        begin
            e422[n] = v[4*n+:4] == sdsc_pkg::MODE_RS422;
            ehalf[n] = v[4*n+:4] == sdsc_pkg::MODE_RS485_2W;
            e485[n] = ehalf[n] || v[4*n+:4] == sdsc_pkg::MODE_RS485_4W;
        end
        @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        check("port_rs422", {24'h0, p422}, {24'h0, e422});
        check("port_rs485", {24'h0, p485}, {24'h0, e485});
        check("port_rs485_half", {24'h0, phalf}, {24'h0, ehalf});
    endtask

    // Read data stand only in the cycle after the strobe, so compare at mid-cycle
    always @(posedge CLK_SYS)
    begin
        rd_pend <= RD;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    always @(negedge CLK_SYS)
    begin
        if (rd_pend && exp_q.size() > 0)
        begin
            r = exp_q.pop_front();
            check($sformatf("rdata_%h", r.a), RDATA, r.d);
        end
    end

    // Main sequence; straps are random and stable from time zero
    initial
    begin
        seed = lfsr(seed);
        straps <= seed[13:0];
        repeat (12) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
        rd(sdsc_pkg::OFF_LINE_DRIVER_SELECT, 32'h0000_0000);
        rd(8'hB8, {26'h0, sdsc_pkg::PM_RESET_DEFAULT});
        for (int k = 0; k < 4; k++)
            rd(ro_off[k], (k == 3) ? {18'h0, straps} : 32'h0000_0000);
        check("strap_value", {18'h0, sv}, {18'h0, straps});
        rd(8'hD0, 32'h0000_0000);
        $display("test reset_values done");
        for (int i = 0; i < 5; i++)
        begin
            seed = lfsr(seed);
            for (int n = 0; n < 8; n++)
                w[4*n+:4] = (i < 4) ? codes[(n + i) % 4] : seed[4*n+:4];
            wr(sdsc_pkg::OFF_LINE_DRIVER_SELECT, w);
            chk_ports(w);
            rd(sdsc_pkg::OFF_LINE_DRIVER_SELECT, w);
        end
        $display("test driver_modes done");
        wr(8'hB8, 32'hFFFF_FFFF);
        rd(8'hB8, 32'h0000_003F);
        check("power_param", {26'h0, pwr}, 32'h0000_003F);
        wr(8'hB8, 32'hFFFF_FFC0);
        rd(8'hB8, 32'h0000_0000);
        for (int k = 0; k < 4; k++)
        begin
            wr(ro_off[k], 32'hFFFF_FFFF);
            rd(ro_off[k], (k == 3) ? {18'h0, straps} : 32'h0000_0000);
        end
        $display("test power_and_readonly done");
        seed = lfsr(seed);
        al(8'hC8, seed);
        rd(8'hC8, {18'h0, seed[13:0]});
        check("strap_value", {18'h0, sv}, {18'h0, seed[13:0]});
        al(sdsc_pkg::OFF_LINE_DRIVER_SELECT, {8{sdsc_pkg::MODE_RS485_2W}});
        chk_ports({8{sdsc_pkg::MODE_RS485_2W}});
        al(8'hB8, 32'h0000_0015);
        rd(8'hB8, 32'h0000_0015);
        al(8'hBC, 32'hFFFF_FFFF);
        rd(8'hBC, 32'h0000_0000);
        // Loader and software hit the same word on one edge; the loader wins
        @(posedge CLK_SYS);
        ADDR <= sdsc_pkg::OFF_LINE_DRIVER_SELECT;
        WDATA <= 32'h0000_0000;
        WR <= 1'b1;
        aa <= sdsc_pkg::OFF_LINE_DRIVER_SELECT;
        ad <= 32'h1111_1111;
        av <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        av <= 1'b0;
        rd(sdsc_pkg::OFF_LINE_DRIVER_SELECT, 32'h1111_1111);
        $display("test autoload done");
        repeat (3) @(posedge CLK_SYS);
        end_of_test();
    end
endmodule

// ===== verilog/sdsc_regs.sv
// Line-driver select, power parameter, test words and strap mirror register bank
`timescale 1ns/1ps
// How it works
// - One 32-bit word holds eight 4-bit driver modes, port n at bits 4n+3:4n.
// - Codes 0000 RS232, 0001 RS422, 1011 RS485 4-wire, 1111 RS485 2-wire drive outputs.
// - Driver modes reset to 0000; EEPROM autoload may overwrite them.
// - Power word: bits 5:0 read-write, autoloadable; bits 31:6 read zero.
// - Three read-only test words reset to zero.
// - Strap word bit 0 low-drive strap, bit 1 high-drive strap, read-only.
// - Strap bits 5:2 transmit current, bits 9:6 de-emphasis straps.
// - Strap bits 11:10 rx termination, bits 13:12 tx termination straps.
// - Straps captured from pins, autoload may replace; bits 31:14 read zero.
module sdsc_regs #(
    parameter logic [5:0] PM_RESET = sdsc_pkg::PM_RESET_DEFAULT
) (
    input wire logic CLK_SYS, // 100 MHz clock
    input wire logic RESETN, // Synchronous reset, active low
    input wire logic [7:0] ADDR, // Byte address
    input wire logic [31:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [31:0] RDATA, // Read data, cycle after RD
    input wire logic LOW_DRIVE_CURRENT_STRAP, // Strap pin
    input wire logic HIGH_DRIVE_CURRENT_STRAP, // Strap pin
    input wire logic [3:0] TRANSMIT_CURRENT_STRAPS, // Strap pins
    input wire logic [3:0] DEEMPHASIS_EQ_STRAPS, // Strap pins
    input wire logic [1:0] RX_TERMINATION_STRAPS, // Strap pins
    input wire logic [1:0] TX_TERMINATION_STRAPS, // Strap pins
    input wire logic AUTOLOAD_VALID, // Loader word strobe, same clock
    input wire logic [7:0] AUTOLOAD_ADDR, // Loader target offset
    input wire logic [31:0] AUTOLOAD_DATA, // Loader data
    output logic [7:0] PORT_RS422, // Per port RS422 transceiver mode
    output logic [7:0] PORT_RS485, // Per port RS485 mode (4 or 2 wire)
    output logic [7:0] PORT_RS485_HALF, // Per port 2-wire RS485
    output logic [5:0] POWER_PARAM, // Power parameter to power logic
    output logic [13:0] STRAP_VALUE // Current strap mirror
);
    logic [31:0] line_driver_select;
    logic [5:0] power_manage_parameter;
    logic [31:0] test_word_one;
    logic [31:0] test_word_two;
    logic [31:0] test_word_three;
    logic [13:0] strap_pin_status;
    logic [13:0] strap_meta;
    logic [13:0] strap_sync;
    sdsc_pkg::sdsc_cap_t cap_state;
    logic [1:0] cap_count;

    // Decode one 4-bit mode field of a port
    function automatic logic [3:0] mode_of(input logic [31:0] w, input int n);
        mode_of = w[n*4 +: 4];
    endfunction

    // Strap pins are asynchronous to the clock, so they pass two flops
    always_ff @(posedge CLK_SYS)
    begin
        strap_meta <= {TX_TERMINATION_STRAPS, RX_TERMINATION_STRAPS, DEEMPHASIS_EQ_STRAPS,
            TRANSMIT_CURRENT_STRAPS, HIGH_DRIVE_CURRENT_STRAP, LOW_DRIVE_CURRENT_STRAP};
        strap_sync <= strap_meta;
    end

    // Capture sequencer waits for the synchroniser to fill after release
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            cap_state <= sdsc_pkg::CAP_WAIT;
            cap_count <= 2'h0;
        end
        else
        begin
            case (cap_state)
                sdsc_pkg::CAP_WAIT:
                begin
                    cap_count <= cap_count + 2'h1;
                    if (cap_count == 2'h2)
                        cap_state <= sdsc_pkg::CAP_DONE;
                end
                sdsc_pkg::CAP_DONE:
                    cap_state <= sdsc_pkg::CAP_DONE;
                default:
                    cap_state <= sdsc_pkg::CAP_WAIT;
            endcase
        end
    end

    // Strap mirror: pins captured once, autoload may replace; software cannot write
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
            strap_pin_status <= 14'h0000;
        else if (AUTOLOAD_VALID && AUTOLOAD_ADDR == sdsc_pkg::OFF_STRAP_PIN_STATUS)
            strap_pin_status <= AUTOLOAD_DATA[13:0];
        else if (cap_state == sdsc_pkg::CAP_WAIT && cap_count == 2'h2)
            strap_pin_status <= strap_sync;
    end

    // Driver select: software write, autoload overwrite, loader wins a same-cycle clash
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
            line_driver_select <= sdsc_pkg::LINE_DRIVER_RESET;
        else if (AUTOLOAD_VALID && AUTOLOAD_ADDR == sdsc_pkg::OFF_LINE_DRIVER_SELECT)
            line_driver_select <= AUTOLOAD_DATA;
        else if (WR && ADDR == sdsc_pkg::OFF_LINE_DRIVER_SELECT)
            line_driver_select <= WDATA;
    end

    // Power parameter: only the low six bits are stored
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
            power_manage_parameter <= PM_RESET;
        else if (AUTOLOAD_VALID && AUTOLOAD_ADDR == sdsc_pkg::OFF_POWER_MANAGE_PARAMETER)
            power_manage_parameter <= AUTOLOAD_DATA[5:0];
        else if (WR && ADDR == sdsc_pkg::OFF_POWER_MANAGE_PARAMETER)
            power_manage_parameter <= WDATA[5:0];
    end

    // Test words have no write path; held at reset value for production test hooks
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            test_word_one <= sdsc_pkg::TEST_WORD_RESET;
            test_word_two <= sdsc_pkg::TEST_WORD_RESET;
            test_word_three <= sdsc_pkg::TEST_WORD_RESET;
        end
    end

    // Read mux; unmapped offsets return zero
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
            RDATA <= 32'h0000_0000;
        else if (!RD)
            RDATA <= 32'h0000_0000;
        else if (ADDR == sdsc_pkg::OFF_LINE_DRIVER_SELECT)
            RDATA <= line_driver_select;
        else if (ADDR == sdsc_pkg::OFF_POWER_MANAGE_PARAMETER)
            RDATA <= {26'h0000000, power_manage_parameter};
        else if (ADDR == sdsc_pkg::OFF_TEST_WORD_ONE)
            RDATA <= test_word_one;
        else if (ADDR == sdsc_pkg::OFF_TEST_WORD_TWO)
            RDATA <= test_word_two;
        else if (ADDR == sdsc_pkg::OFF_TEST_WORD_THREE)
            RDATA <= test_word_three;
        else if (ADDR == sdsc_pkg::OFF_STRAP_PIN_STATUS)
            RDATA <= {18'h00000, strap_pin_status};
        else
            RDATA <= 32'h0000_0000;
    end

    // Transceiver mode outputs; undefined codes fall back to RS232 (all low)
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            PORT_RS422 <= 8'h00;
            PORT_RS485 <= 8'h00;
            PORT_RS485_HALF <= 8'h00;
        end
        else
        begin
            for (int n = 0; n < sdsc_pkg::NUM_PORTS; n++)
            begin
                PORT_RS422[n] <= mode_of(line_driver_select, n) == sdsc_pkg::MODE_RS422;
                PORT_RS485[n] <= mode_of(line_driver_select, n) == sdsc_pkg::MODE_RS485_4W
                    || mode_of(line_driver_select, n) == sdsc_pkg::MODE_RS485_2W;
                PORT_RS485_HALF[n] <= mode_of(line_driver_select, n) == sdsc_pkg::MODE_RS485_2W;
            end
        end
    end

    // Plain copies for neighbouring logic
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            POWER_PARAM <= 6'h00;
            STRAP_VALUE <= 14'h0000;
        end
        else
        begin
            POWER_PARAM <= power_manage_parameter;
            STRAP_VALUE <= strap_pin_status;
        end
    end

    AST_RESET_MODES: assert property (@(posedge CLK_SYS) !RESETN |=> line_driver_select == 32'h0)
        else $error("driver modes not zero after reset");
    AST_WRITE_STORES: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        WR && ADDR == 8'hB4 && !AUTOLOAD_VALID |=> line_driver_select == $past(WDATA))
        else $error("driver select write lost");
    AST_MODE_OUT: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        line_driver_select[3:0] == 4'hF |=> PORT_RS485_HALF[0] && PORT_RS485[0])
        else $error("2-wire mode not driven");
    AST_RS422_OUT: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        line_driver_select[31:28] == 4'h1 |=> PORT_RS422[7] && !PORT_RS485[7])
        else $error("RS422 mode on port 7 not driven");
    AST_PM_UPPER: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $past(RD) && $past(ADDR) == 8'hB8 |-> RDATA[31:6] == 26'h0)
        else $error("power reserved bits nonzero");
    AST_TEST_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        RD && (ADDR == 8'hBC || ADDR == 8'hC0 || ADDR == 8'hC4) |=> RDATA == 32'h0)
        else $error("test word nonzero");
    AST_STRAP_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        cap_state == sdsc_pkg::CAP_WAIT && cap_count == 2'h2 && !AUTOLOAD_VALID
        |=> strap_pin_status == $past(strap_sync))
        else $error("strap capture missed");
    AST_STRAP_READ: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        RD && ADDR == 8'hC8 |=> RDATA == {18'h0, $past(strap_pin_status)})
        else $error("strap read wrong");
    AST_STRAP_NOWRITE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        cap_state == sdsc_pkg::CAP_DONE && !AUTOLOAD_VALID |=> $stable(strap_pin_status))
        else $error("strap word changed by software");

    // Named steps for the bus and loader properties below
    sequence seq_sw_write(logic [7:0] off);
        WR && ADDR == off && !(AUTOLOAD_VALID && AUTOLOAD_ADDR == off);
    endsequence

    sequence seq_load(logic [7:0] off);
        AUTOLOAD_VALID && AUTOLOAD_ADDR == off;
    endsequence

    sequence seq_read(logic [7:0] off);
        RD && ADDR == off;
    endsequence

    // Capture edge: last wait count with no strap-word load beside it
    sequence seq_capture;
        cap_state == sdsc_pkg::CAP_WAIT && cap_count == 2'h2
            && !(AUTOLOAD_VALID && AUTOLOAD_ADDR == sdsc_pkg::OFF_STRAP_PIN_STATUS);
    endsequence

    // Reset release: one low sample, then the first high one
    sequence seq_release;
        !RESETN ##1 RESETN;
    endsequence

    // Every output is quiet one edge into reset
    AST_RESET_OUTS: assert property (@(posedge CLK_SYS)
        !RESETN |=> RDATA == 32'h0000_0000 && PORT_RS422 == 8'h00 && PORT_RS485 == 8'h00
        && PORT_RS485_HALF == 8'h00 && POWER_PARAM == 6'h00 && STRAP_VALUE == 14'h0000)
        else $error("outputs not cleared by reset");

    // Loader overwrites the driver modes
    AST_LOAD_MODES: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_load(sdsc_pkg::OFF_LINE_DRIVER_SELECT) |=> line_driver_select == $past(AUTOLOAD_DATA))
        else $error("driver select autoload lost");

    // A same-edge clash must not let the software word through
    AST_LOAD_BEATS_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        AUTOLOAD_VALID && AUTOLOAD_ADDR == 8'hB4 && WR && ADDR == 8'hB4
        |=> line_driver_select == $past(AUTOLOAD_DATA))
        else $error("software write beat the loader");

    // Read of the driver word returns the stored modes
    AST_READ_MODES: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_read(sdsc_pkg::OFF_LINE_DRIVER_SELECT) |=> RDATA == $past(line_driver_select))
        else $error("driver select read wrong");

    // Software write of the driver word lands whole
    AST_SW_MODES: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_sw_write(sdsc_pkg::OFF_LINE_DRIVER_SELECT) |=> line_driver_select == $past(WDATA))
        else $error("driver select software write lost");

    // Code 0000 leaves port 0 in plain RS232
    AST_PORT0_RS232: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        line_driver_select[3:0] == 4'h0 |=> !PORT_RS422[0] && !PORT_RS485[0] && !PORT_RS485_HALF[0])
        else $error("RS232 mode on port 0 not driven");

    // Code 1011 gives full-duplex RS485 on port 3
    AST_PORT3_RS485_4W: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        line_driver_select[15:12] == 4'hB |=> PORT_RS485[3] && !PORT_RS485_HALF[3] && !PORT_RS422[3])
        else $error("4-wire mode on port 3 not driven");

    // Code 0001 gives RS422 on port 5
    AST_PORT5_RS422: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        line_driver_select[23:20] == 4'h1 |=> PORT_RS422[5] && !PORT_RS485[5])
        else $error("RS422 mode on port 5 not driven");

    // Software write keeps only the six low bits
    AST_PM_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_sw_write(sdsc_pkg::OFF_POWER_MANAGE_PARAMETER) |=> power_manage_parameter == $past(WDATA[5:0]))
        else $error("power write lost");

    // Loader preloads the power parameter
    AST_PM_LOAD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_load(sdsc_pkg::OFF_POWER_MANAGE_PARAMETER) |=> power_manage_parameter == $past(AUTOLOAD_DATA[5:0]))
        else $error("power autoload lost");

    // Power read returns the stored field
    AST_PM_READ: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_read(sdsc_pkg::OFF_POWER_MANAGE_PARAMETER) |=> RDATA == {26'h0000000, $past(power_manage_parameter)})
        else $error("power read wrong");

    // Power copy trails the register by one edge
    AST_PM_COPY: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        1'b1 |=> POWER_PARAM == $past(power_manage_parameter))
        else $error("power copy wrong");

    // Test words never move once out of reset
    AST_TEST_HELD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        1'b1 |=> $stable(test_word_one) && $stable(test_word_two) && $stable(test_word_three))
        else $error("test word moved");

    // Writes aimed at the test words change nothing
    AST_TEST_NOWRITE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        WR && (ADDR == 8'hBC || ADDR == 8'hC0 || ADDR == 8'hC4) |=> test_word_one == 32'h0 && test_word_two == 32'h0 && test_word_three == 32'h0)
        else $error("test word written");

    // Software write to the strap word after capture is ignored
    AST_STRAP_SW_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        WR && ADDR == 8'hC8 && !AUTOLOAD_VALID && cap_state == sdsc_pkg::CAP_DONE |=> $stable(strap_pin_status))
        else $error("strap word written by software");

    // Unmapped offsets read back zero
    AST_UNMAPPED_READ: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        RD && (ADDR < 8'hB4 || ADDR > 8'hC8 || ADDR[1:0] != 2'b00) |=> RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Drive-current strap bits land at 1:0
    AST_STRAP_LOW: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_capture |=> strap_pin_status[1:0] == $past(strap_sync[1:0]))
        else $error("drive strap bits misplaced");

    // Transmit current and de-emphasis straps land at 9:2
    AST_STRAP_MID: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_capture |=> strap_pin_status[9:2] == $past(strap_sync[9:2]))
        else $error("current or de-emphasis straps misplaced");

    // Termination straps land at 13:10
    AST_STRAP_TERM: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_capture |=> strap_pin_status[13:10] == $past(strap_sync[13:10]))
        else $error("termination straps misplaced");

    // Loader replaces the captured straps
    AST_STRAP_LOAD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        seq_load(sdsc_pkg::OFF_STRAP_PIN_STATUS) |=> strap_pin_status == $past(AUTOLOAD_DATA[13:0]))
        else $error("strap autoload lost");

    // Strap copy trails the register by one edge
    AST_STRAP_COPY: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        1'b1 |=> STRAP_VALUE == $past(strap_pin_status))
        else $error("strap copy wrong");

    // Capture is done by the fourth edge after release
    AST_CAPTURE_TIME: assert property (@(posedge CLK_SYS)
        seq_release ##1 RESETN [*2] |=> cap_state == sdsc_pkg::CAP_DONE)
        else $error("strap capture late");

    // Capture happens once; later pin moves are ignored
    AST_CAPTURE_STAYS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        cap_state == sdsc_pkg::CAP_DONE |=> cap_state == sdsc_pkg::CAP_DONE)
        else $error("capture sequencer left done");

    // Read data stand only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !RD |=> RDATA == 32'h0000_0000)
        else $error("read data not zero when idle");
endmodule
